// ---- dbls_pkg.sv ----
package dbls_pkg;

	// ----------------------------------------------------------------
	// bus and dram geometry
	// ----------------------------------------------------------------
	localparam int DBLS_BUS_W = 32;
	localparam int DBLS_BANKS = 4;
	localparam int DBLS_LANES = 4;
	localparam int DBLS_DADDR_W = 9;

	// address field positions
	localparam int DBLS_BANK_HI = 21;
	localparam int DBLS_BANK_LO = 20;
	localparam int DBLS_ROW_HI = 19;
	localparam int DBLS_ROW_LO = 11;
	localparam int DBLS_COL_HI = 10;
	localparam int DBLS_COL_LO = 2;
	localparam int DBLS_REGION_LO = 22;

	// banks actually fitted on the board, one to four
	localparam logic [2:0] DBLS_BANKS_FITTED = 3'h4;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [3:0] DBLS_STROBES_IDLE = 4'hF;
	localparam logic [8:0] DBLS_DADDR_RST = 9'h000;
	localparam logic [31:0] DBLS_ADDR_RST = 32'h0000_0000;
	localparam int DBLS_CLK_MHZ = 40;
	localparam int DBLS_PRECHARGE_NS = 50;
	localparam logic [2:0] DBLS_PRECHARGE_CYC =
		3'((DBLS_PRECHARGE_NS * DBLS_CLK_MHZ + 999) / 1000);

	typedef enum logic [2:0] {
		DBLS_IDLE,
		DBLS_ROW,
		DBLS_COL,
		DBLS_HOLD,
		DBLS_PRECHARGE
	} dbls_state_t;

	// one-hot bank pick from a two-bit bank code
	function automatic logic [3:0] dbls_bank_onehot(input logic [1:0] code);
		dbls_bank_onehot = 4'h1 << code;
	endfunction : dbls_bank_onehot

endpackage : dbls_pkg

// ---- dbls_addr_if.sv ----
`timescale 1ns/10ps
interface dbls_addr_if;
	import dbls_pkg::*;
	logic latch_stb;
	logic [DBLS_BUS_W-1:0] bus;
	logic [1:0] bank_code;
	logic [3:0] bank_sel;
	logic in_region;
	logic [DBLS_DADDR_W-1:0] row_addr;
	logic [DBLS_DADDR_W-1:0] col_addr;

	modport ctrl (output latch_stb, output bus, input bank_code, input bank_sel,
		input in_region, input row_addr, input col_addr);
	modport path (input latch_stb, input bus, output bank_code, output bank_sel,
		output in_region, output row_addr, output col_addr);
endinterface : dbls_addr_if

// ---- dbls_addr_path.sv ----
`timescale 1ns/10ps
module dbls_addr_path
	import dbls_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	dbls_addr_if.path ap
);

	typedef struct packed {
		logic [DBLS_BUS_W-1:0] addr;
	} dbls_path_st_t;

	dbls_path_st_t s_q;
	dbls_path_st_t s_d;

	// --------------------------------------------------------------
	// address latch
	// --------------------------------------------------------------
	// the bus carries data after the address phase, so hold the address
	always_comb begin
		s_d = s_q;
		if (ap.latch_stb) begin
			s_d.addr = ap.bus;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.addr <= DBLS_ADDR_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------------------------
	// decode of the held address
	// --------------------------------------------------------------
	// dram lives only in the bottom 4MB; banks are contiguous megabytes
	assign ap.in_region = (s_q.addr[DBLS_BUS_W-1:DBLS_REGION_LO] == '0);
	assign ap.bank_code = s_q.addr[DBLS_BANK_HI:DBLS_BANK_LO];
	assign ap.bank_sel = dbls_bank_onehot(s_q.addr[DBLS_BANK_HI:DBLS_BANK_LO]);
	assign ap.row_addr = s_q.addr[DBLS_ROW_HI:DBLS_ROW_LO];
	assign ap.col_addr = s_q.addr[DBLS_COL_HI:DBLS_COL_LO];

endmodule : dbls_addr_path

// ---- dbls_bank_lane_select.sv ----
`timescale 1ns/10ps
module dbls_bank_lane_select
	import dbls_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [DBLS_BUS_W-1:0] cpu_addr_data_i,
	input wire logic addr_latch_i,
	input wire logic memory_region_select_i,
	input wire logic read_strobe_n_i,
	input wire logic cpu_store_strobe_n_i,
	input wire logic [DBLS_LANES-1:0] byte_enable_n_i,
	output logic [DBLS_BANKS-1:0] bank_row_strobe_n_o,
	output logic [DBLS_BANKS-1:0] bank_store_enable_n_o,
	output logic [DBLS_LANES-1:0] lane_column_strobe_n_o,
	output logic [DBLS_DADDR_W-1:0] dram_addr_o,
	output logic access_busy_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// one record holds the whole sequencer, so the next-state copy is always complete
	typedef struct packed {
		dbls_state_t state;
		logic is_write;
		logic [DBLS_LANES-1:0] lanes;
		logic [DBLS_BANKS-1:0] bank;
		logic [2:0] pre_cnt;
		logic [DBLS_BANKS-1:0] ras_n;
		logic [DBLS_BANKS-1:0] we_n;
		logic [DBLS_LANES-1:0] cas_n;
		logic [DBLS_DADDR_W-1:0] daddr;
		logic busy;
	} dbls_st_t;

	dbls_st_t s_q;
	dbls_st_t s_d;

	// carrier to the address latch and its decoder
	dbls_addr_if ap ();

	// request decode, combinational from the pins, the latched address and the sequencer state
	logic rd_req;
	logic wr_req;
	logic start;
	logic fitted;
	logic held;
	logic [DBLS_BANKS-1:0] pick_bank;
	logic [DBLS_LANES-1:0] pick_lanes;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// active-low strobe word for a one-hot bank pick; row strobe and store
	// enable both come from here, so they can never name different banks
	function automatic logic [DBLS_BANKS-1:0] bank_strobe_n(input logic [DBLS_BANKS-1:0] pick);
		bank_strobe_n = ~pick;
	endfunction : bank_strobe_n

	// lanes an access touches: reads fetch the whole word, writes only the
	// bytes the processor names, so a byte store never clobbers its neighbours
	function automatic logic [DBLS_LANES-1:0] lane_pick(input logic write, input logic [DBLS_LANES-1:0] be_n);
		if (write) begin
			lane_pick = ~be_n;
		end else begin
			lane_pick = {DBLS_LANES{1'b1}};
		end
	endfunction : lane_pick

	// true while the strobe that opened the access is still low
	function automatic logic strobe_held(input logic write, input logic rd, input logic wr);
		if (write) begin
			strobe_held = wr;
		end else begin
			strobe_held = rd;
		end
	endfunction : strobe_held

	// precharge ends on the last counted cycle; a zero count ends at once
	function automatic logic precharge_done(input logic [2:0] cnt);
		precharge_done = (cnt <= 3'h1);
	endfunction : precharge_done

	// ----------------------------------------------------------------
	// address path
	// ----------------------------------------------------------------
	// the whole design sits on the processor system clock (40 MHz here)
	assign ap.latch_stb = addr_latch_i;
	assign ap.bus = cpu_addr_data_i;

	dbls_addr_path u_path (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.ap(ap.path)
	);

	// ----------------------------------------------------------------
	// request qualification
	// ----------------------------------------------------------------
	// an unfitted bank is never strobed, so its range simply floats
	assign rd_req = !read_strobe_n_i;
	assign wr_req = !cpu_store_strobe_n_i;
	assign fitted = ({1'b0, ap.bank_code} < DBLS_BANKS_FITTED);
	assign start = memory_region_select_i && ap.in_region && fitted && (rd_req || wr_req);

	// ----------------------------------------------------------------
	// lane and bank steering
	// ----------------------------------------------------------------
	// byte enables matter only on the edge the access is taken
	assign pick_bank = ap.bank_sel;
	assign pick_lanes = lane_pick(wr_req, byte_enable_n_i);
	// the release test follows the strobe that was taken, not the other
	assign held = strobe_held(s_q.is_write, rd_req, wr_req);

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	// row strobe first with row address, then column address and lanes;
	// strobes hold until the processor drops its strobe, then precharge
	always_comb begin
		s_d = s_q;
		case (s_q.state)
			DBLS_IDLE: begin
				// strobes parked high; row address shown early so it is settled
				s_d.ras_n = DBLS_STROBES_IDLE;
				s_d.we_n = DBLS_STROBES_IDLE;
				s_d.cas_n = DBLS_STROBES_IDLE;
				s_d.busy = 1'b0;
				s_d.daddr = ap.row_addr;
				if (start) begin
					s_d.state = DBLS_ROW;
					s_d.busy = 1'b1;
					s_d.is_write = wr_req;
					s_d.bank = pick_bank;
					// reads fetch the full word; writes touch named lanes only
					s_d.lanes = pick_lanes;
					s_d.ras_n = bank_strobe_n(pick_bank);
				end
			end

			DBLS_ROW: begin
				// row is open: swap to column address, store enable goes early
				s_d.state = DBLS_COL;
				s_d.daddr = ap.col_addr;
				s_d.we_n = s_q.is_write ? bank_strobe_n(s_q.bank) : DBLS_STROBES_IDLE;
			end

			DBLS_COL: begin
				s_d.state = DBLS_HOLD;
				// column strobes are common to all banks: row strobe picks
				s_d.cas_n = ~s_q.lanes;
			end

			DBLS_HOLD: begin
				// strobes stand until the processor lets go of its strobe
				if (!held) begin
					s_d.state = DBLS_PRECHARGE;
					s_d.ras_n = DBLS_STROBES_IDLE;
					s_d.we_n = DBLS_STROBES_IDLE;
					s_d.cas_n = DBLS_STROBES_IDLE;
					s_d.pre_cnt = DBLS_PRECHARGE_CYC;
				end
			end

			DBLS_PRECHARGE: begin
				// row strobe must stay high long enough before reuse
				if (precharge_done(s_q.pre_cnt)) begin
					s_d.state = DBLS_IDLE;
					s_d.busy = 1'b0;
				end else begin
					s_d.pre_cnt = s_q.pre_cnt - 3'h1;
				end
			end

			default: begin
				// an unused state code falls back to idle
				s_d.state = DBLS_IDLE;
			end
		endcase
	end

	// async clear parks every strobe high so no bank sees a false access
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.state <= DBLS_IDLE;
			s_q.is_write <= 1'b0;
			s_q.lanes <= 4'h0;
			s_q.bank <= 4'h0;
			s_q.pre_cnt <= 3'h0;
			s_q.ras_n <= DBLS_STROBES_IDLE;
			s_q.we_n <= DBLS_STROBES_IDLE;
			s_q.cas_n <= DBLS_STROBES_IDLE;
			s_q.daddr <= DBLS_DADDR_RST;
			s_q.busy <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign bank_row_strobe_n_o = s_q.ras_n;
	assign bank_store_enable_n_o = s_q.we_n;
	assign lane_column_strobe_n_o = s_q.cas_n;
	assign dram_addr_o = s_q.daddr;
	assign access_busy_o = s_q.busy;

endmodule : dbls_bank_lane_select

// ---- dbls_props.sv ----
`timescale 1ns/10ps
module dbls_props
	import dbls_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [31:0] cpu_addr_data_i,
	input wire logic addr_latch_i,
	input wire logic memory_region_select_i,
	input wire logic read_strobe_n_i,
	input wire logic cpu_store_strobe_n_i,
	input wire logic [3:0] byte_enable_n_i,
	input wire logic [3:0] bank_row_strobe_n_o,
	input wire logic [3:0] bank_store_enable_n_o,
	input wire logic [3:0] lane_column_strobe_n_o,
	input wire logic [8:0] dram_addr_o,
	input wire logic access_busy_o
);
	// ----------------------------------------------------------------
	// shadow latch and access start
	// ----------------------------------------------------------------
	logic [31:0] la_q;
	logic go;
	logic ok;
	// shadow of the address latch, so the checker decodes what the block decodes
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) la_q <= 32'h0000_0000;
		else if (addr_latch_i) la_q <= cpu_addr_data_i;
	end
	// a request counts only while idle; both strobes low still counts
	assign go = !access_busy_o && memory_region_select_i && !(read_strobe_n_i && cpu_store_strobe_n_i);
	assign ok = la_q[31:22] == 10'h000;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	AST_BANK: assert property (go && ok |=> access_busy_o && bank_row_strobe_n_o == ~(4'h1 << la_q[21:20]))
		else $error("wrong bank row strobe");
	AST_REGION: assert property (go && !ok |=> !access_busy_o)
		else $error("access outside dram region");
	AST_ADDR: assert property (go && ok |=> dram_addr_o == la_q[19:11] ##1 dram_addr_o == la_q[10:2])
		else $error("dram address order");
	AST_WE: assert property (go && ok && !cpu_store_strobe_n_i ##1 !cpu_store_strobe_n_i |=>
		bank_store_enable_n_o == bank_row_strobe_n_o) else $error("store enable bank");
	AST_RD_NO_WE: assert property (!read_strobe_n_i && cpu_store_strobe_n_i |-> bank_store_enable_n_o == 4'hF)
		else $error("store enable on read");
	AST_CAS: assert property (go && ok ##1 (!(read_strobe_n_i && cpu_store_strobe_n_i))[*2] |=>
		lane_column_strobe_n_o == (cpu_store_strobe_n_i ? 4'h0 : $past(byte_enable_n_i, 3))) else $error("lanes");
	AST_END: assert property (access_busy_o && $rose(read_strobe_n_i && cpu_store_strobe_n_i) |=>
		(bank_row_strobe_n_o & bank_store_enable_n_o & lane_column_strobe_n_o) == 4'hF
		##1 access_busy_o ##1 !access_busy_o) else $error("access end");
	AST_IDLE: assert property (!access_busy_o |-> (bank_row_strobe_n_o & lane_column_strobe_n_o) == 4'hF)
		else $error("strobe while idle");
endmodule : dbls_props
bind dbls_bank_lane_select dbls_props dbls_props_i (.*);

// ---- dbls_cpu_model.sv ----
`timescale 1ns/10ps
module dbls_cpu_model (
	input wire logic clock_i,
	output logic [31:0] bus_o,
	output logic latch_o,
	output logic sel_o,
	output logic rd_n_o,
	output logic st_n_o,
	output logic [3:0] be_n_o
);
	// ----------------------------------------------------------------
	// processor bus side
	// ----------------------------------------------------------------
	// quiet bus at time zero
	initial begin
		bus_o = 32'h0000_0000;
		latch_o = 1'b0;
		sel_o = 1'b0;
		rd_n_o = 1'b1;
		st_n_o = 1'b1;
		be_n_o = 4'hF;
	end
	// address phase then strobe; the address is gone once latched, so no stale value
	task automatic begin_access(input logic [31:0] a, input logic wr, input logic [3:0] be);
		@(posedge clock_i) #1;
		latch_o = 1'b1;
		bus_o = a;
		@(posedge clock_i) #1;
		latch_o = 1'b0;
		bus_o = ~a;
		sel_o = 1'b1;
		be_n_o = be;
		if (wr) st_n_o = 1'b0;
		else rd_n_o = 1'b0;
	endtask : begin_access
	// strobe release ends the access
	task automatic end_access();
		@(posedge clock_i) #1;
		rd_n_o = 1'b1;
		st_n_o = 1'b1;
		sel_o = 1'b0;
		bus_o = ~bus_o;
	endtask : end_access
endmodule : dbls_cpu_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	import dbls_pkg::*;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] bus;
	logic latch, sel, rd_n, st_n, busy;
	logic [3:0] be_n, ras_n, we_n, cas_n;
	logic [8:0] daddr;
	logic [31:0] seed = 32'hCF51925F;
	int fail_count = 0;
	int checks = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	dbls_cpu_model dbls_cpu_model_i (.clock_i(clk), .bus_o(bus), .latch_o(latch), .sel_o(sel),
		.rd_n_o(rd_n), .st_n_o(st_n), .be_n_o(be_n));
	dbls_bank_lane_select dbls_bank_lane_select_i (.clock_i(clk), .rst_n_i(rst_n), .cpu_addr_data_i(bus),
		.addr_latch_i(latch), .memory_region_select_i(sel), .read_strobe_n_i(rd_n), .cpu_store_strobe_n_i(st_n),
		.byte_enable_n_i(be_n), .bank_row_strobe_n_o(ras_n), .bank_store_enable_n_o(we_n),
		.lane_column_strobe_n_o(cas_n), .dram_addr_o(daddr), .access_busy_o(busy));
	// xorshift keeps runs repeatable
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [3:0] row_exp(input logic [1:0] b);
		return ~(4'h1 << b);
	endfunction : row_exp
	task automatic check_v(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_v
	task automatic results();
		if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// random accesses; first four hit the top word of each bank, fifth sits just above 4MB
	initial begin
		logic [31:0] a;
		logic [31:0] r;
		logic wr;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			a = rnd() & 32'hFFFF_FFFC;
			if (r[3:0] != 4'h0) a[31:22] = 10'h000;
			if (i < 4) a = {10'h000, i[1:0], 20'hFFFFC};
			if (i == 4) a = 32'h0040_0000;
			wr = r[4];
			dbls_cpu_model_i.begin_access(a, wr, r[8:5]);
			@(posedge clk) #1;
			if (a[31:22] != 10'h000) begin
				check_v(busy, 9'h000);
			end else begin
				check_v(ras_n, row_exp(a[21:20]));
				check_v(daddr, a[19:11]);
				@(posedge clk) #1;
				check_v(daddr, a[10:2]);
				check_v(we_n, wr ? row_exp(a[21:20]) : 4'hF);
				repeat (1 + r[10:9]) @(posedge clk) #1;
				check_v(cas_n, wr ? r[8:5] : 4'h0);
			end
			dbls_cpu_model_i.end_access();
			@(posedge clk) #1;
			check_v({ras_n, we_n}, 9'h0FF);
			check_v(cas_n, 9'h00F);
			repeat (2) @(posedge clk) #1;
			check_v(busy, 9'h000);
		end
		results();
	end
	// hang guard, well past forty accesses
	initial begin
		#40000;
		fail_count++;
		results();
	end
endmodule : tb_top
